// ==== hw/urs_pkg.sv ====
// Package for one channel of the dual UART: register map, field positions,
// reset values, interrupt bit layout and the state enumerations.
// Assumes a single clock domain and byte-wide register access.
package urs_pkg;

  // ----------
  // Register map
  // ----------
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_HOLD = 5'h00;
  localparam logic [4:0] OFS_IER = 5'h01;
  localparam logic [4:0] OFS_ISR_FCR = 5'h02;
  localparam logic [4:0] OFS_LCR = 5'h03;
  localparam logic [4:0] OFS_MCR = 5'h04;
  localparam logic [4:0] OFS_LSR = 5'h05;
  localparam logic [4:0] OFS_MSR = 5'h06;
  localparam logic [4:0] OFS_SPR = 5'h07;
  localparam logic [4:0] OFS_DLL = 5'h08;
  localparam logic [4:0] OFS_DLM = 5'h09;
  localparam logic [4:0] OFS_DLD = 5'h0a;
  localparam logic [4:0] OFS_AFR = 5'h0b;
  localparam logic [4:0] OFS_EFR = 5'h0c;
  localparam logic [4:0] OFS_RESUME_CHAR_FIRST = 5'h0d;
  localparam logic [4:0] OFS_RESUME_CHAR_SECOND = 5'h0e;
  localparam logic [4:0] OFS_PAUSE_CHAR_FIRST = 5'h0f;
  localparam logic [4:0] OFS_PAUSE_CHAR_SECOND = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h11;
  localparam logic [4:0] OFS_IRQ_EN = 5'h12;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h13;

  // ----------
  // Reset values
  // ----------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DLM = 8'h00;
  localparam logic [7:0] RST_DLL = 8'h01;
  localparam logic [7:0] RST_SPR = 8'hff;
  localparam logic [3:0] RST_MODEM_N = 4'hf;

  // ----------
  // Field positions and codes
  // ----------
  localparam int unsigned EFR_AUTO_CTS = 7;
  localparam int unsigned EFR_ENH_EN = 4;
  localparam int unsigned IER_RX = 0;
  localparam int unsigned IER_THR = 1;
  localparam int unsigned IER_MODEM = 3;
  localparam int unsigned MCR_DTR = 0;
  localparam int unsigned MCR_RTS = 1;
  localparam int unsigned MCR_OP2 = 3;
  localparam int unsigned MSR_TERI = 2;
  localparam logic [7:0] ENH_IER_MASK = 8'hf0;
  localparam logic [7:0] ENH_FCR_MASK = 8'h30;
  localparam logic [7:0] ENH_MCR_MASK = 8'he0;
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_RX = 8'h04;
  localparam logic [7:0] ISR_THR = 8'h02;
  localparam logic [7:0] ISR_MODEM = 8'h00;

  // ----------
  // Event interrupt layout and bit timing
  // ----------
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_TX = 1;
  localparam int unsigned IRQ_MODEM = 2;
  localparam int unsigned IRQ_CTS = 3;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] WORD_BASE = 3'h4;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} urs_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urs_rx_e;

endpackage

// ==== hw/urs_channel.sv ====
// One UART channel: register file with reset state, baud generator,
// transmitter gated by automatic clear-to-send, simple receiver, modem
// status and an event interrupt. Assumes modem and serial inputs arrive
// asynchronously and that por_i is pulsed once at power-up.
//
// Summary of operation
// RULE_01: With auto clear-to-send on, a high clear-to-send input stops sending.
// RULE_02: Sending resumes once clear-to-send input returns low.
// RULE_03: Auto clear-to-send enable bit resets to 0, input then ignored.
// RULE_04: Four read/write flow-control characters: two resume, two pause.
// RULE_05: Divisor bytes reset to 0x00/0x01 only at power-up, not reset pin.
// RULE_06: Listed control and character registers clear to 0x00 on reset.
// RULE_07: Interrupt source reads 0x01, nothing pending, after reset.
// RULE_08: Line status reads 0x60 after reset.
// RULE_09: Modem status deltas clear on reset; upper nibble shows inverted inputs.
// RULE_10: Scratchpad resets to 0xFF.
// RULE_11: Holding registers are undefined after reset.
// RULE_12: Serial out, user output two, RTS, DTR, rx ready drive high at reset.
// RULE_13: Transmit-ready drives low and interrupt stays low at reset.
// RULE_14: A character already shifting completes before transmission halts.
`timescale 1ns/10ps
`default_nettype none

module urs_channel (
  input wire logic ref_clk_i, // Device clock, 250 MHz.
  input wire logic rst_i, // Hardware reset, async, active high.
  input wire logic por_i, // Power-up reset, async, active high.
  input wire logic [4:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, cycle after rd_i.
  input wire logic rx_i, // Serial receive input.
  input wire logic cts_n_i, // Clear to send, active low.
  input wire logic dsr_n_i, // Data set ready, active low.
  input wire logic ri_n_i, // Ring indicator, active low.
  input wire logic cd_n_i, // Carrier detect, active low.
  output logic tx_o, // Serial transmit output.
  output logic rts_n_o, // Request to send, active low.
  output logic dtr_n_o, // Data terminal ready, active low.
  output logic user_output_two_n_o, // User output two, active low.
  output logic rx_ready_n_o, // Receive data ready, active low.
  output logic tx_ready_n_o, // Transmit holding free, active low.
  output logic irq_o // Interrupt, active high level.
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0] ier_q, fcr_q, lcr_q, mcr_q, spr_q, dld_q, afr_q, efr_q;
  logic [7:0] resume_char_first_q, resume_char_second_q, pause_char_first_q, pause_char_second_q, dll_q, dlm_q;
  logic [7:0] rhr_q, thr_q, rdata_q, rd_mux, isr_val, lsr_val, msr_val;
  logic [3:0] modem_s1_q, modem_s2_q, modem_prev_q, delta_q, delta_set;
  logic rx_s1_q, rx_s2_q;
  logic [15:0] baud_cnt_q, div_last;
  logic tick;
  logic thr_full_q, data_ready_q, overrun_q, frame_err_q;
  logic [1:0] settle_q;
  logic [3:0] tx_sub_q, rx_sub_q;
  logic [2:0] tx_bit_q, rx_bit_q, word_last;
  logic [7:0] tx_shift_q, rx_shift_q;
  logic tx_line_q, tx_load, tx_done, rx_done, cts_ok;
  logic [urs_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q, irq_evt;
  logic wr_hold, wr_enh, rd_hold, rd_lsr, rd_msr;
  urs_pkg::urs_tx_e tx_state_q;
  urs_pkg::urs_rx_e rx_state_q;

  // Enhanced bits only change while the enhanced enable bit is set.
  function automatic logic [7:0] merge_enh(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] mask,
                                           input logic en);
    merge_enh = en ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction

  assign wr_enh = efr_q[urs_pkg::EFR_ENH_EN];
  assign wr_hold = wr_i && (addr_i == urs_pkg::OFS_HOLD);
  assign rd_hold = rd_i && (addr_i == urs_pkg::OFS_HOLD);
  assign rd_lsr = rd_i && (addr_i == urs_pkg::OFS_LSR);
  assign rd_msr = rd_i && (addr_i == urs_pkg::OFS_MSR);

  // ---------------------------------------------------------------------------
  // Synchronisers for pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      modem_s1_q <= urs_pkg::RST_MODEM_N;
      modem_s2_q <= urs_pkg::RST_MODEM_N;
      modem_prev_q <= urs_pkg::RST_MODEM_N;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      settle_q <= 2'h0;
    end else begin
      modem_s1_q <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      modem_s2_q <= modem_s1_q;
      modem_prev_q <= modem_s2_q;
      rx_s1_q <= rx_i;
      rx_s2_q <= rx_s1_q;
      settle_q <= settle_q + 2'(settle_q != 2'h3);
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ier_q <= urs_pkg::RST_CTRL; // RULE_06
      fcr_q <= urs_pkg::RST_CTRL; // RULE_06
      lcr_q <= urs_pkg::RST_CTRL; // RULE_06
      mcr_q <= urs_pkg::RST_CTRL; // RULE_06
      dld_q <= urs_pkg::RST_CTRL; // RULE_06
      afr_q <= urs_pkg::RST_CTRL; // RULE_06
      efr_q <= urs_pkg::RST_CTRL; // RULE_03
      resume_char_first_q <= urs_pkg::RST_CTRL; // RULE_06
      resume_char_second_q <= urs_pkg::RST_CTRL; // RULE_06
      pause_char_first_q <= urs_pkg::RST_CTRL; // RULE_06
      pause_char_second_q <= urs_pkg::RST_CTRL; // RULE_06
      spr_q <= urs_pkg::RST_SPR; // RULE_10
      irq_en_q <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        urs_pkg::OFS_IER:
          ier_q <= merge_enh(ier_q, wdata_i, urs_pkg::ENH_IER_MASK, wr_enh);
        urs_pkg::OFS_ISR_FCR:
          fcr_q <= merge_enh(fcr_q, wdata_i, urs_pkg::ENH_FCR_MASK, wr_enh);
        urs_pkg::OFS_LCR: lcr_q <= wdata_i;
        urs_pkg::OFS_MCR:
          mcr_q <= merge_enh(mcr_q, wdata_i, urs_pkg::ENH_MCR_MASK, wr_enh);
        urs_pkg::OFS_SPR: spr_q <= wdata_i;
        urs_pkg::OFS_DLD: if (wr_enh) dld_q <= wdata_i;
        urs_pkg::OFS_AFR: afr_q <= wdata_i;
        urs_pkg::OFS_EFR: efr_q <= wdata_i;
        urs_pkg::OFS_RESUME_CHAR_FIRST: resume_char_first_q <= wdata_i; // RULE_04
        urs_pkg::OFS_RESUME_CHAR_SECOND: resume_char_second_q <= wdata_i; // RULE_04
        urs_pkg::OFS_PAUSE_CHAR_FIRST: pause_char_first_q <= wdata_i; // RULE_04
        urs_pkg::OFS_PAUSE_CHAR_SECOND: pause_char_second_q <= wdata_i; // RULE_04
        urs_pkg::OFS_IRQ_EN: irq_en_q <= wdata_i[urs_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // The divisor survives the reset pin so a running link keeps its rate.
  always_ff @(posedge ref_clk_i or posedge por_i) begin
    if (por_i) begin
      dlm_q <= urs_pkg::RST_DLM; // RULE_05
      dll_q <= urs_pkg::RST_DLL; // RULE_05
    end else if (wr_i && (addr_i == urs_pkg::OFS_DLM)) begin
      dlm_q <= wdata_i;
    end else if (wr_i && (addr_i == urs_pkg::OFS_DLL)) begin
      dll_q <= wdata_i;
    end
  end

  // Holding registers carry no reset; their contents are undefined.
  always_ff @(posedge ref_clk_i) begin
    if (wr_hold) begin
      thr_q <= wdata_i; // RULE_11
    end
    if (rx_done) begin
      rhr_q <= rx_shift_q; // RULE_11
    end
  end

  // ---------------------------------------------------------------------------
  // Baud generator, one tick per sixteenth of a bit
  // ---------------------------------------------------------------------------
  assign div_last = ({dlm_q, dll_q} == 16'h0000) ? 16'h0000
                                                 : {dlm_q, dll_q} - 16'h0001;
  assign tick = (baud_cnt_q >= div_last);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_cnt_q <= 16'h0000;
    end else if (tick) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end

  assign word_last = {1'b0, lcr_q[1:0]} + urs_pkg::WORD_BASE;

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  // The gate is tested only in idle, so a character in flight always ends.
  assign cts_ok = !efr_q[urs_pkg::EFR_AUTO_CTS] || !modem_s2_q[0]; // RULE_01
  assign tx_load = (tx_state_q == urs_pkg::TX_IDLE) && thr_full_q
                   && cts_ok; // RULE_02 RULE_14
  assign tx_done = (tx_state_q == urs_pkg::TX_STOP) && tick
                   && (tx_sub_q == urs_pkg::TICK_LAST);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= urs_pkg::TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_line_q <= 1'b1; // RULE_12
    end else begin
      unique case (tx_state_q)
        urs_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_state_q <= urs_pkg::TX_START;
            tx_shift_q <= thr_q;
            tx_sub_q <= 4'h0;
            tx_line_q <= 1'b0;
          end
        end
        urs_pkg::TX_START: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == urs_pkg::TICK_LAST) begin
              tx_state_q <= urs_pkg::TX_DATA;
              tx_bit_q <= 3'h0;
              tx_line_q <= tx_shift_q[0];
            end
          end
        end
        urs_pkg::TX_DATA: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == urs_pkg::TICK_LAST) begin
              if (tx_bit_q == word_last) begin
                tx_state_q <= urs_pkg::TX_STOP;
                tx_line_q <= 1'b1;
              end else begin
                tx_bit_q <= tx_bit_q + 3'h1;
                tx_line_q <= tx_shift_q[tx_bit_q + 3'h1];
              end
            end
          end
        end
        urs_pkg::TX_STOP: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == urs_pkg::TICK_LAST) begin
              tx_state_q <= urs_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // A host write in the load cycle wins and keeps the holding register full.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_full_q <= 1'b0;
    end else if (wr_hold) begin
      thr_full_q <= 1'b1;
    end else if (tx_load) begin
      thr_full_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  assign rx_done = (rx_state_q == urs_pkg::RX_STOP) && tick
                   && (rx_sub_q == urs_pkg::TICK_LAST) && rx_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_q <= urs_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= 8'h00;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      unique case (rx_state_q)
        urs_pkg::RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rx_s2_q) begin
            rx_state_q <= urs_pkg::RX_START;
          end
        end
        urs_pkg::RX_START: begin
          if (rx_sub_q == urs_pkg::TICK_MID) begin
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_state_q <= rx_s2_q ? urs_pkg::RX_IDLE : urs_pkg::RX_DATA;
          end
        end
        urs_pkg::RX_DATA: begin
          if (rx_sub_q == urs_pkg::TICK_LAST) begin
            rx_shift_q[rx_bit_q] <= rx_s2_q;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == word_last) begin
              rx_state_q <= urs_pkg::RX_STOP;
            end
          end
        end
        urs_pkg::RX_STOP: begin
          if (rx_sub_q == urs_pkg::TICK_LAST) begin
            rx_state_q <= urs_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Line and modem status flags; a set in the clearing cycle wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ready_q <= 1'b0; // RULE_08
      overrun_q <= 1'b0; // RULE_08
      frame_err_q <= 1'b0; // RULE_08
      delta_q <= 4'h0; // RULE_09
    end else begin
      if (rx_done) begin
        data_ready_q <= 1'b1;
      end else if (rd_hold) begin
        data_ready_q <= 1'b0;
      end
      if (rx_done && data_ready_q && !rd_hold) begin
        overrun_q <= 1'b1;
      end else if (rd_lsr) begin
        overrun_q <= 1'b0;
      end
      if (tick && (rx_state_q == urs_pkg::RX_STOP)
          && (rx_sub_q == urs_pkg::TICK_LAST) && !rx_s2_q) begin
        frame_err_q <= 1'b1;
      end else if (rd_lsr) begin
        frame_err_q <= 1'b0;
      end
      delta_q <= (rd_msr ? 4'h0 : delta_q) | delta_set;
    end
  end

  // Ring counts only on its trailing edge; no deltas while sync fills.
  always_comb begin
    delta_set = (settle_q == 2'h3) ? (modem_s2_q ^ modem_prev_q) : 4'h0;
    delta_set[urs_pkg::MSR_TERI] = delta_set[urs_pkg::MSR_TERI]
                                   && modem_s2_q[urs_pkg::MSR_TERI];
  end

  assign msr_val = {~modem_s2_q, delta_q}; // RULE_09
  assign lsr_val = {1'b0, !thr_full_q && (tx_state_q == urs_pkg::TX_IDLE),
                    !thr_full_q, 1'b0, frame_err_q, 1'b0, overrun_q,
                    data_ready_q}; // RULE_08

  // With every enable clear the source reads as nothing pending.
  always_comb begin
    isr_val = urs_pkg::ISR_NONE; // RULE_07
    if (ier_q[urs_pkg::IER_RX] && data_ready_q) begin
      isr_val = urs_pkg::ISR_RX;
    end else if (ier_q[urs_pkg::IER_THR] && !thr_full_q) begin
      isr_val = urs_pkg::ISR_THR;
    end else if (ier_q[urs_pkg::IER_MODEM] && (delta_q != 4'h0)) begin
      isr_val = urs_pkg::ISR_MODEM;
    end
  end

  // ----------
  // Event interrupt
  // ----------
  assign irq_evt = {(delta_set[0] != 1'b0), (delta_set != 4'h0), tx_done,
                    rx_done};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (wr_i && (addr_i == urs_pkg::OFS_IRQ_CLR)) begin
      irq_stat_q <= (irq_stat_q & ~wdata_i[urs_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (addr_i)
      urs_pkg::OFS_HOLD: rd_mux = rhr_q;
      urs_pkg::OFS_IER: rd_mux = ier_q;
      urs_pkg::OFS_ISR_FCR: rd_mux = isr_val;
      urs_pkg::OFS_LCR: rd_mux = lcr_q;
      urs_pkg::OFS_MCR: rd_mux = mcr_q;
      urs_pkg::OFS_LSR: rd_mux = lsr_val;
      urs_pkg::OFS_MSR: rd_mux = msr_val;
      urs_pkg::OFS_SPR: rd_mux = spr_q;
      urs_pkg::OFS_DLL: rd_mux = dll_q;
      urs_pkg::OFS_DLM: rd_mux = dlm_q;
      urs_pkg::OFS_DLD: rd_mux = dld_q;
      urs_pkg::OFS_AFR: rd_mux = afr_q;
      urs_pkg::OFS_EFR: rd_mux = efr_q;
      urs_pkg::OFS_RESUME_CHAR_FIRST: rd_mux = resume_char_first_q; // RULE_04
      urs_pkg::OFS_RESUME_CHAR_SECOND: rd_mux = resume_char_second_q; // RULE_04
      urs_pkg::OFS_PAUSE_CHAR_FIRST: rd_mux = pause_char_first_q; // RULE_04
      urs_pkg::OFS_PAUSE_CHAR_SECOND: rd_mux = pause_char_second_q; // RULE_04
      urs_pkg::OFS_IRQ_STAT: rd_mux = {4'h0, irq_stat_q};
      urs_pkg::OFS_IRQ_EN: rd_mux = {4'h0, irq_en_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1; // RULE_12
      dtr_n_o <= 1'b1; // RULE_12
      user_output_two_n_o <= 1'b1; // RULE_12
      rx_ready_n_o <= 1'b1; // RULE_12
      tx_ready_n_o <= 1'b0; // RULE_13
      irq_o <= 1'b0; // RULE_13
    end else begin
      rts_n_o <= !mcr_q[urs_pkg::MCR_RTS];
      dtr_n_o <= !mcr_q[urs_pkg::MCR_DTR];
      user_output_two_n_o <= !mcr_q[urs_pkg::MCR_OP2];
      rx_ready_n_o <= !data_ready_q;
      tx_ready_n_o <= thr_full_q;
      irq_o <= ((irq_stat_q & irq_en_q) != '0);
    end
  end

  assign tx_o = tx_line_q; // RULE_12
  assign rdata_o = rdata_q;

endmodule // urs_channel

`default_nettype wire

// ==== verif/urs_checker.sv ====
// Checker for one UART channel.
// Bound into urs_channel; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module urs_checker (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic [4:0] addr_i, // Address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [7:0] rdata_o, // Read data.
  input wire logic cts_n_i, // Clear to send.
  input wire logic tx_o, // Serial out.
  input wire logic rts_n_o, // RTS.
  input wire logic dtr_n_o, // DTR.
  input wire logic user_output_two_n_o, // User output two.
  input wire logic rx_ready_n_o, // Receive ready.
  input wire logic tx_ready_n_o, // Transmit ready.
  input wire logic irq_o // Interrupt.
);
  // ----
  // Helper state
  // ----
  // Fresh means no write since reset, so reset values still read back.
  logic fresh_q, auto_q, en_q;
  logic [2:0] cts_cnt_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {fresh_q, auto_q, en_q, cts_cnt_q} <= 6'h20;
    end else begin
      fresh_q <= fresh_q && !wr_i;
      if (wr_i && addr_i == urs_pkg::OFS_EFR) auto_q <= wdata_i[7];
      if (wr_i && addr_i == urs_pkg::OFS_IRQ_EN) en_q <= |wdata_i[3:0];
      cts_cnt_q <= cts_n_i ? cts_cnt_q + 3'(cts_cnt_q != 3'h7) : 3'h0;
    end
  end
  chk_reset_high: assert property (
    $fell(rst_i) |-> tx_o && rts_n_o && dtr_n_o && user_output_two_n_o &&
    rx_ready_n_o) else $error("Idle-high outputs wrong after reset.");
  chk_reset_low: assert property (
    $fell(rst_i) |-> !tx_ready_n_o && !irq_o)
    else $error("Low outputs wrong after reset.");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("Read data not zero outside a read.");
  chk_lsr_reset: assert property (
    fresh_q && rd_i && addr_i == urs_pkg::OFS_LSR |=> rdata_o == 8'h60)
    else $error("Line status wrong after reset.");
  chk_isr_reset: assert property (
    fresh_q && rd_i && addr_i == urs_pkg::OFS_ISR_FCR |=> rdata_o == 8'h01)
    else $error("Interrupt source wrong after reset.");
  chk_spr_reset: assert property (
    fresh_q && rd_i && addr_i == urs_pkg::OFS_SPR |=> rdata_o == 8'hff)
    else $error("Scratchpad wrong after reset.");
  chk_cts_blocks: assert property (
    auto_q && $past(auto_q, 4) && cts_cnt_q == 3'h7 && tx_ready_n_o
    |=> tx_ready_n_o) else $error("Holding loaded while CTS high.");
  chk_irq_masked: assert property ((!en_q) [*2] |-> !irq_o)
    else $error("Interrupt high with all enables off.");
endmodule // urs_checker
bind urs_channel urs_checker chk_u (.*);
`default_nettype wire

// ==== verif/urs_remote.sv ====
// Remote terminal model: receives and sends 8N1 frames.
// Assumes divisor 1, sixteen clock cycles per bit.
`timescale 1ns/10ps
`default_nettype none
module urs_remote (
  input wire logic ref_clk_i, // Clock.
  input wire logic line_i, // From channel.
  output logic line_o, // Data to the channel.
  output logic cts_n_o, // Clear to send.
  output logic dsr_n_o, // Data set ready.
  output logic ri_n_o, // Ring indicator.
  output logic cd_n_o // Carrier detect.
);
  // ----
  // Line handling
  // ----
  localparam int BIT_CYC = 16;
  logic [7:0] got_q [$];
  logic [8:0] sh;
  initial begin
    {line_o, cts_n_o, dsr_n_o, ri_n_o, cd_n_o} = 5'h17;
  end
  // A bad stop bit is queued as unknown so that any compare fails.
  always begin
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk_i);
      sh[i] = line_i;
    end
    got_q.push_back(sh[8] ? sh[7:0] : 8'hxx);
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_i);
      line_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk_i);
    end
  endtask
endmodule // urs_remote
`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench for one UART channel.
// Assumes channel, checker and remote model files.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk_i, rst_i, por_i, wr_i, rd_i, rx_i, cts_n_i, dsr_n_i, ri_n_i;
  logic cd_n_i, tx_o, rts_n_o, dtr_n_o, user_output_two_n_o, rx_ready_n_o;
  logic tx_ready_n_o, irq_o;
  logic [4:0] addr_i;
  logic [7:0] wdata_i, rdata_o, b;
  logic [7:0] cv [4];
  logic [7:0] exp_q [$];
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // ----
  // Address high byte, reset value low byte; CTS idles low.
  // ----
  localparam logic [15:0] RTAB [14] = '{16'h0100, 16'h0201, 16'h0300,
    16'h0400, 16'h0560, 16'h0610, 16'h07ff, 16'h0a00, 16'h0b00, 16'h0c00,
    16'h0d00, 16'h0e00, 16'h0f00, 16'h1000};
  urs_channel dut_u (.*);
  urs_remote rem_u (.ref_clk_i(ref_clk_i), .line_i(tx_o), .line_o(rx_i),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i), .cd_n_o(cd_n_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic wait_char;
    int n = 0;
    while (rem_u.got_q.size() == 0 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(n < 3000 ? rem_u.got_q.pop_front() : 8'hxx, exp_q.pop_front());
  endtask
  initial begin
    {rst_i, por_i, wr_i, rd_i, addr_i, wdata_i} = 17'h18000;
    b = 8'($urandom(95793));
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      #1 chk({1'b0, tx_o, rts_n_o, dtr_n_o, user_output_two_n_o,
        rx_ready_n_o, tx_ready_n_o, irq_o}, 8'h7c);
      for (int i = 0; i < 14; i++) begin
        rchk(RTAB[i][12:8], RTAB[i][7:0]);
      end
      rchk(urs_pkg::OFS_DLM, k ? 8'h5a : 8'h00);
      rchk(urs_pkg::OFS_DLL, k ? 8'h3c : 8'h01);
      wr(5'h14, 8'hff);
      rchk(5'h14, 8'h00);
      for (int i = 0; i < 4; i++) begin
        cv[i] = 8'($urandom);
        wr(urs_pkg::OFS_RESUME_CHAR_FIRST + 5'(i), cv[i]);
      end
      for (int i = 0; i < 4; i++) begin
        rchk(urs_pkg::OFS_RESUME_CHAR_FIRST + 5'(i), cv[i]);
      end
      wr(urs_pkg::OFS_SPR, 8'($urandom));
      wr(urs_pkg::OFS_DLM, 8'h5a);
      wr(urs_pkg::OFS_DLL, 8'h3c);
    end
    wr(urs_pkg::OFS_DLM, 8'h00);
    wr(urs_pkg::OFS_DLL, 8'h01);
    wr(urs_pkg::OFS_LCR, 8'h03);
    rem_u.cts_n_o <= 1'b1;
    wr(urs_pkg::OFS_IRQ_EN, 8'h02);
    wr(urs_pkg::OFS_IRQ_CLR, 8'h0f);
    b = 8'($urandom);
    exp_q.push_back(b);
    wr(urs_pkg::OFS_HOLD, b);
    wait_char;
    repeat (30) @(posedge ref_clk_i);
    #1 chk({7'h0, irq_o}, 8'h01);
    rchk(urs_pkg::OFS_IRQ_STAT, 8'h02);
    wr(urs_pkg::OFS_IRQ_EN, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    #1 chk({7'h0, irq_o}, 8'h00);
    wr(urs_pkg::OFS_IRQ_CLR, 8'h02);
    rchk(urs_pkg::OFS_IRQ_STAT, 8'h00);
    wr(urs_pkg::OFS_EFR, 8'h80);
    b = 8'($urandom);
    wr(urs_pkg::OFS_HOLD, b);
    repeat (400) @(posedge ref_clk_i);
    #1 chk({7'h0, tx_ready_n_o}, 8'h01);
    chk(8'(rem_u.got_q.size()), 8'h00);
    exp_q.push_back(b);
    @(posedge ref_clk_i);
    rem_u.cts_n_o <= 1'b0;
    wait_char;
    for (int i = 0; i < 2; i++) begin
      repeat (2) @(posedge ref_clk_i);
      while (tx_ready_n_o) @(posedge ref_clk_i);
      b = 8'($urandom);
      exp_q.push_back(b);
      wr(urs_pkg::OFS_HOLD, b);
    end
    repeat (60) @(posedge ref_clk_i);
    rem_u.cts_n_o <= 1'b1;
    wait_char;
    repeat (400) @(posedge ref_clk_i);
    chk(8'(rem_u.got_q.size()), 8'h00);
    rem_u.cts_n_o <= 1'b0;
    wait_char;
    b = 8'($urandom);
    rem_u.send(b);
    repeat (4) @(posedge ref_clk_i);
    #1 chk({7'h0, rx_ready_n_o}, 8'h00);
    rchk(urs_pkg::OFS_HOLD, b);
    results;
  end
endmodule // tb_top
`default_nettype wire
